// file: hw/lidr_pkg.sv
// Function
// [RULE1] watchdog input filter: 3-bit select, 0..51.2 ms
// [RULE2] general input function: enable and voltage-select codes
// [RULE3] codes 1010..1100 route to low-power controls
// [RULE4] input one select 7:4=0100, zero 3:0=0011
// [RULE5] low-power/enable filters 64 us steps, reset 0001
// [RULE6] general input filters 64 us steps to 960 us
// [RULE7] pass level only after stable for time
//
// Purpose: constants for logic input debounce and routing
// Assumes: 100 MHz core clock
// Notes:   register index equals printed offset
package lidr_pkg;
   localparam logic [7:0] ADDR_WDT_FILT  = 8'h0e;
   localparam logic [7:0] ADDR_FUNC_SEL  = 8'h0f;
   localparam logic [7:0] ADDR_ENLP_FILT = 8'h10;
   localparam logic [7:0] ADDR_GPI_FILT  = 8'h11;
   localparam logic [7:0] RST_WDT_FILT   = 8'h02;
   localparam logic [7:0] RST_FUNC_SEL   = 8'h43;
   localparam logic [7:0] RST_ENLP_FILT  = 8'h11;
   localparam logic [7:0] RST_GPI_FILT   = 8'h11;
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         TICK_US        = 64;
   localparam int         TICK_CYCLES    = TICK_US * 1000 / CLK_PERIOD_NS;
   // 0.8 ms is no whole number of 64 us ticks, so the watchdog counts 100 us
   localparam int         WDT_BASE_US    = 800;
   localparam int         WDT_TICK_US    = 100;
   localparam int         WDT_TICK_CYC   = WDT_TICK_US * 1000 / CLK_PERIOD_NS;
   localparam logic [3:0] FN_GLOBAL_ENABLE      = 4'h0;
   localparam logic [3:0] FN_GLOBAL_VOLTAGE_SELECT    = 4'h5;
   localparam logic [3:0] FN_GLB_LP      = 4'ha;
   localparam logic [3:0] FN_M1_LP       = 4'hb;
   localparam logic [3:0] FN_M2_LP       = 4'hc;
endpackage : lidr_pkg

// file: hw/lidr_filter.sv
// Purpose: one-input debounce filter counting tick enables
// Assumes: input synchronous to the clock
// Notes:   a zero time passes the level straight through
`timescale 1ns/1ps
module lidr_filter #(
   parameter int CW = 10
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_tick,
   input  wire logic [CW-1:0] i_ticks,
   input  wire logic          i_raw,
   output logic               o_level
);
   logic [CW-1:0] cnt;
   wire           differs = (i_raw != o_level);
   wire           bypass  = (i_ticks == '0);
   wire           done    = i_tick && (cnt + CW'(1) >= i_ticks);

   // restart the count on any bounce so only a stable level gets through
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt     <= '0;
         o_level <= 1'b0;
      end else if (!differs) begin
         cnt <= '0;                                 // RULE7
      end else if (bypass || done) begin
         o_level <= i_raw;                          // RULE7
         cnt     <= '0;
      end else if (i_tick) begin
         cnt <= cnt + CW'(1);
      end
   end

   chk_bypass_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE7
      (differs && bypass) |=> (o_level == $past(i_raw)))
      else $error("zero time did not pass level");
   chk_no_early_change: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE7
      (!bypass && !differs) |=> $stable(o_level))
      else $error("level moved while input matched");
endmodule // lidr_filter

// file: hw/lidr_top.sv
// Purpose: debounce logic inputs and route general inputs
// Assumes: byte-wide register port at printed offsets
// Notes:   watchdog code 110 treated as no filtering
`timescale 1ns/1ps
module lidr_top #(
   parameter int TICK_CYC = lidr_pkg::TICK_CYCLES,
   parameter int WDT_CYC  = lidr_pkg::WDT_TICK_CYC
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   input  wire logic       i_watchdog_reset_input,
   input  wire logic       i_enable_input,
   input  wire logic       i_low_power_input,
   input  wire logic       i_general_input_zero,
   input  wire logic       i_general_input_one,
   output logic            o_watchdog_reset,
   output logic            o_enable,
   output logic            o_low_power,
   output logic            o_global_enable,
   output logic      [3:0] o_master_enable,
   output logic            o_global_voltage_select,
   output logic      [3:0] o_master_voltage_select,
   output logic            o_global_low_power,
   output logic      [1:0] o_master_low_power
);
   // configuration registers, one per offset
   logic [7:0]  wdt_filt;
   logic [7:0]  func_sel;
   logic [7:0]  enlp_filt;
   logic [7:0]  gpi_filt;
   logic [7:0]  next_rdata;
   // shared dividers; 24 bits hold either default period
   logic [23:0] tick_cnt;
   logic [23:0] wdt_cnt;
   logic        tick;
   logic        wdt_tick;
   // filtered levels {input one, input zero, low power, enable, watchdog}
   logic [4:0]  lv;

   // address decode shared by the write strobes and the read select
   wire         hit_wdt   = (i_reg_addr == lidr_pkg::ADDR_WDT_FILT);
   wire         hit_func  = (i_reg_addr == lidr_pkg::ADDR_FUNC_SEL);
   wire         hit_enlp  = (i_reg_addr == lidr_pkg::ADDR_ENLP_FILT);
   wire         hit_gpi   = (i_reg_addr == lidr_pkg::ADDR_GPI_FILT);

   // divider wrap points; the tick itself is registered one cycle later
   wire         tick_wrap = (tick_cnt == 24'(TICK_CYC - 1));
   wire         wdt_wrap  = (wdt_cnt == 24'(WDT_CYC - 1));

   // register writes; reserved watchdog bits held at zero
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wdt_filt  <= lidr_pkg::RST_WDT_FILT;   // RULE1
         func_sel  <= lidr_pkg::RST_FUNC_SEL;   // RULE4
         enlp_filt <= lidr_pkg::RST_ENLP_FILT;  // RULE5
         gpi_filt  <= lidr_pkg::RST_GPI_FILT;   // RULE6
      end else if (i_reg_wr) begin
         if (hit_wdt)  wdt_filt  <= {5'h00, i_reg_wdata[2:0]};  // RULE1
         if (hit_func) func_sel  <= i_reg_wdata;                // RULE4
         if (hit_enlp) enlp_filt <= i_reg_wdata;                // RULE5
         if (hit_gpi)  gpi_filt  <= i_reg_wdata;                // RULE6
      end
   end

   chk_reset_values: assert property (@(posedge i_core_clk) // RULE4
      !i_rst_n |=> (func_sel == lidr_pkg::RST_FUNC_SEL &&
                    wdt_filt == lidr_pkg::RST_WDT_FILT &&
                    enlp_filt == lidr_pkg::RST_ENLP_FILT &&
                    gpi_filt == lidr_pkg::RST_GPI_FILT))
      else $error("bad reset value");

   // a one in the reserved watchdog bits would read back as a false code
   chk_wdt_reserved: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      wdt_filt[7:3] == 5'h00)
      else $error("reserved watchdog bits set");

   // read select; unmapped offsets read zero
   assign next_rdata = hit_wdt  ? wdt_filt  :
                       hit_func ? func_sel  :
                       hit_enlp ? enlp_filt :
                       hit_gpi  ? gpi_filt  : 8'h00;

   // read data registered so it stands a full cycle after the address
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else begin
         o_reg_rdata <= next_rdata;
      end
   end

   chk_read_func: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE4
      hit_func |=> (o_reg_rdata == $past(func_sel)))
      else $error("function select read back wrong");

   // 64 us tick divider shared by four filters, 100 us divider for the watchdog only
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         tick_cnt <= 24'h000000;
         wdt_cnt  <= 24'h000000;
         tick     <= 1'b0;
         wdt_tick <= 1'b0;
      end else begin
         tick     <= tick_wrap;
         wdt_tick <= wdt_wrap;
         tick_cnt <= tick_wrap ? 24'h000000 : tick_cnt + 24'h000001;
         wdt_cnt  <= wdt_wrap ? 24'h000000 : wdt_cnt + 24'h000001;
      end
   end

   // watchdog code to 100 us units: 8 << (code-1), codes 0 and 6 are zero, code 7 is 512
   wire [2:0] wcode = wdt_filt[2:0];
   wire [9:0] wdt_units = (wcode == 3'h0 || wcode == 3'h6) ? 10'h000 :  // RULE1
                          (wcode == 3'h7) ? 10'h200 : (10'h008 << (wcode - 3'h1));

   // 0.8 ms is eight 100 us ticks and 51.2 ms is 512 of them
   chk_wdt_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      (wcode == 3'h1) |-> (wdt_units == 10'h008))
      else $error("watchdog shortest time wrong");
   chk_wdt_longest: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE1
      (wcode == 3'h7) |-> (wdt_units == 10'h200))
      else $error("watchdog longest time wrong");

   // per-input filter times, 4-bit fields widened to the filter counter
   wire [9:0] en_ticks = {6'h00, enlp_filt[3:0]};   // RULE5
   wire [9:0] lp_ticks = {6'h00, enlp_filt[7:4]};   // RULE5
   wire [9:0] g0_ticks = {6'h00, gpi_filt[3:0]};    // RULE6
   wire [9:0] g1_ticks = {6'h00, gpi_filt[7:4]};    // RULE6

   // watchdog input counts 100 us ticks so its steps land exactly
   lidr_filter #(
      .CW(10)
   ) u_wdt (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_tick     (wdt_tick),
      .i_ticks    (wdt_units),
      .i_raw      (i_watchdog_reset_input),
      .o_level    (lv[0])
   );

   // enable input on the 64 us tick
   lidr_filter #(
      .CW(10)
   ) u_en (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_tick     (tick),
      .i_ticks    (en_ticks),
      .i_raw      (i_enable_input),
      .o_level    (lv[1])
   );

   // low-power input on the 64 us tick
   lidr_filter #(
      .CW(10)
   ) u_lp (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_tick     (tick),
      .i_ticks    (lp_ticks),
      .i_raw      (i_low_power_input),
      .o_level    (lv[2])
   );

   // general input zero; shares the tick phase, so delay jitters by one tick
   lidr_filter #(
      .CW(10)
   ) u_g0 (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_tick     (tick),
      .i_ticks    (g0_ticks),
      .i_raw      (i_general_input_zero),
      .o_level    (lv[3])
   );

   // general input one
   lidr_filter #(
      .CW(10)
   ) u_g1 (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_tick     (tick),
      .i_ticks    (g1_ticks),
      .i_raw      (i_general_input_one),
      .o_level    (lv[4])
   );

   // one-hot decode of a function code into 13 routing targets
   function automatic logic [12:0] route(input logic [3:0] code, input logic lvl);
      route = lvl ? (13'h0001 << code) : 13'h0000;  // codes above 1100 route nowhere
   endfunction

   wire [3:0]  fn_zero = func_sel[3:0];            // RULE4
   wire [3:0]  fn_one  = func_sel[7:4];            // RULE4
   wire [12:0] tgt     = route(fn_zero, lv[3]) | route(fn_one, lv[4]);

   // dedicated levels straight from their filters, routed targets decoded
   assign o_watchdog_reset        = lv[0];
   assign o_enable                = lv[1];
   assign o_low_power             = lv[2];
   assign o_global_enable         = tgt[lidr_pkg::FN_GLOBAL_ENABLE];        // RULE2
   assign o_master_enable         = tgt[4:1];                        // RULE2
   assign o_global_voltage_select = tgt[lidr_pkg::FN_GLOBAL_VOLTAGE_SELECT];      // RULE2
   assign o_master_voltage_select = tgt[9:6];                        // RULE2
   assign o_global_low_power      = tgt[lidr_pkg::FN_GLB_LP];        // RULE3
   assign o_master_low_power      = {tgt[lidr_pkg::FN_M2_LP], tgt[lidr_pkg::FN_M1_LP]}; // RULE3

   // routing checks on the outputs, one or two per function family, plus unused codes
   chk_route_lowpow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      (fn_zero == 4'ha && lv[3]) |-> o_global_low_power)
      else $error("low-power route missing");
   chk_route_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      (fn_one == 4'h4 && lv[4]) |-> o_master_enable[3])
      else $error("master enable route missing");
   chk_route_lp_one: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE3
      (fn_zero == lidr_pkg::FN_M1_LP && lv[3]) |-> o_master_low_power[0])
      else $error("master one low-power route missing");
   chk_route_vsel: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      (fn_zero == lidr_pkg::FN_GLOBAL_VOLTAGE_SELECT && lv[3]) |-> o_global_voltage_select)
      else $error("global voltage-select route missing");
   chk_route_unused: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE2
      (fn_zero > 4'hc && !lv[4]) |-> ({o_global_enable, o_master_enable,
         o_global_voltage_select, o_master_voltage_select, o_global_low_power,
         o_master_low_power} == 13'h0000))
      else $error("unused code drove a target");

   // main scenarios worth seeing at least once
   cov_wdt_max: cover property (@(posedge i_core_clk) wcode == 3'h7 && $rose(lv[0]));
   cov_gpi_vsel: cover property (@(posedge i_core_clk) o_global_voltage_select);
   cov_en_pass: cover property (@(posedge i_core_clk) $rose(o_enable));
endmodule // lidr_top

// file: testbench/lidr_host_model.sv
// Purpose: host side driving the logic input pins
// Assumes: one core clock
// Notes:   pins move only just after a rising edge
`timescale 1ns/1ps
module lidr_host_model (
   input  wire logic       i_core_clk,
   input  wire logic [4:0] i_level,
   output logic      [4:0] o_pins
);
   // launch requested levels at the edge, as a host port would
   always_ff @(posedge i_core_clk) begin
      o_pins <= i_level;
   end
endmodule // lidr_host_model

// file: testbench/test_logic_input_debounce_and_routing.sv
// Purpose: self-checking bench for input debounce and routing
// Assumes: tick shortened to 4 cycles, watchdog tick to 5
// Notes:   pins {watchdog, enable, low power, input one, input zero}
`timescale 1ns/1ps
module test_logic_input_debounce_and_routing;
   localparam int T = 4;
   localparam int W = 5;
   logic        clk, rst_n, wr;
   logic [7:0]  addr, wdata, rdata;
   logic [4:0]  lvl, pins;
   logic [12:0] rt;
   logic [3:0]  flt;
   int          err_count, n_checks;
   logic        wdt_o, en_o, lp_o;
   assign flt = {wdt_o, en_o, lp_o, rt[12]};
   lidr_host_model host (.i_core_clk(clk), .i_level(lvl), .o_pins(pins));
   lidr_top #(.TICK_CYC(T), .WDT_CYC(W)) dut (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_watchdog_reset_input(pins[4]), .i_enable_input(pins[3]),
      .i_low_power_input(pins[2]), .i_general_input_one(pins[1]),
      .i_general_input_zero(pins[0]), .o_watchdog_reset(wdt_o), .o_enable(en_o),
      .o_low_power(lp_o), .o_global_enable(rt[12]), .o_master_enable(rt[11:8]),
      .o_global_voltage_select(rt[7]), .o_master_voltage_select(rt[6:3]),
      .o_global_low_power(rt[2]), .o_master_low_power(rt[1:0]));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(string nm, int lo, int hi, int g);
      n_checks++;
      if (g < lo || g > hi) begin
         err_count++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // every drive lands 1 ns after an edge, clear of the sampling point
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1); // idle edge so a following write never retoggles wr at once
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] e);
      addr = a;
      cyc(2);
      chk("rdata", {5'h00, e}, {5'h00, rdata});
   endtask
   // output bit raised by each function code
   function automatic int pos(int c);
      return c == 0 ? 12 : c < 5 ? 7 + c : c == 5 ? 7 : c < 10 ? c - 3 : c == 10 ? 2 : c - 11;
   endfunction
   task automatic regs_scn;
      rreg(8'h0e, 8'h02);
      rreg(8'h0f, 8'h43);
      rreg(8'h10, 8'h11);
      rreg(8'h11, 8'h11);
      wreg(8'h0e, 8'hff);
      rreg(8'h0e, 8'h07);
      wreg(8'h14, 8'h5a);
      rreg(8'h14, 8'h00);
   endtask
   // reset routing first, then input zero unfiltered through all 16 codes
   task automatic route_scn;
      lvl = 5'h03;
      cyc(12);
      chk("route", 13'h0c00, rt);
      lvl = 5'h00;
      cyc(12);
      wreg(8'h11, 8'h00);
      lvl = 5'h01;
      for (int c = 0; c < 16; c++) begin
         wreg(8'h0f, {4'hd, c[3:0]});
         cyc(3);
         chk("route", (c < 13) ? 13'h0001 << pos(c) : 13'h0000, rt);
      end
      lvl = 5'h00;
      cyc(3);
   endtask
   // short pulse must be swallowed, long level passes within the window
   task automatic deb(int p, int o, int lo, int hi);
      int n;
      n = 0;
      lvl[p] = 1'b1;
      cyc(lo / 2);
      lvl[p] = 1'b0;
      cyc(lo);
      chk("glitch", 13'h0000, {12'h000, flt[o]});
      lvl[p] = 1'b1;
      while (flt[o] !== 1'b1 && n < hi) begin
         cyc(1);
         n++;
      end
      chk_rng("delay", lo, hi - 1, n);
      if (n >= hi) tally_and_finish();
      lvl[p] = 1'b0;
      cyc(hi);
   endtask
   task automatic deb_scn;
      wreg(8'h10, 8'h38);
      deb(3, 2, 7 * T, 8 * T + 6);
      deb(2, 1, 2 * T, 3 * T + 6);
      wreg(8'h0e, 8'h01);
      deb(4, 3, 7 * W, 8 * W + 6);
      wreg(8'h0e, 8'h07);
      deb(4, 3, 511 * W, 512 * W + 6);
      wreg(8'h0e, 8'h06);
      deb(4, 3, 2, 4);
      wreg(8'h0e, 8'h00);
      deb(4, 3, 2, 4);
      wreg(8'h0f, 8'h0f);
      wreg(8'h11, 8'hf0);
      deb(1, 0, 14 * T, 15 * T + 6);
   endtask
   // mid-run reset must restore every register default
   task automatic reset_scn;
      wreg(8'h0f, 8'h5a);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      regs_scn();
   endtask
   initial begin
      err_count = 0;
      n_checks = 0;
      rst_n = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      lvl = 5'h00;
      cyc(16);
      rst_n = 1'b1;
      regs_scn();
      route_scn();
      deb_scn();
      reset_scn();
      tally_and_finish();
   end
endmodule // test_logic_input_debounce_and_routing
